//--- core/dbs_pkg.sv
package dbs_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SIZE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] COUNT_OFS = 8'h0c;

  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_REPEAT_BIT = 1;
  localparam int CTRL_BURST_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] SIZE_RESET = 16'h0000;

  // ****************************************
  // status fields
  // ****************************************
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_BUSREQ_BIT = 1;
  localparam int STAT_CPUREQ_BIT = 2;
  localparam int STAT_HALTOK_BIT = 3;
  localparam int STAT_HALTED_BIT = 4;
  localparam int STAT_WAIT_BIT = 5;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [3:0] WINDOW_CYCLES = 4'd10;
  localparam logic [3:0] ENGINE_SLOTS = 4'd8;
  localparam logic [1:0] QUIET_CYCLES = 2'd3;

  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CPU} dbs_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic valid;
  } dbs_req_t;

  typedef struct packed {
    logic cpuReq;
    logic haltReq;
    logic modWait;
  } dbs_sys_in_t;

  typedef struct packed {
    logic engineReq;
    logic engineGrant;
    logic cpuGrant;
    logic haltGrant;
  } dbs_sys_out_t;

endpackage : dbs_pkg

//--- core/dbs_engine.sv
// Functional notes
// - in repeat mode a finished transfer reloads the size counter and restarts unless enable is clear.
// - in burst-block mode each ten-cycle window gives eight cycles to the engine and two to the core.
// - halt waits until three cycles after any engine transfer the engine no longer requests the bus.
// - halt also waits until the core itself does not request the bus.
// - repeat burst-block with enable kept set requests the bus forever, so halt is never granted.
// - an engine access must not reach a module while it is asserting a wait state.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module dbs_engine
  import dbs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // system side
  input wire dbs_sys_in_t sysIn,
  output dbs_sys_out_t sysOut
);

  // ****************************************
  // bus slave
  // ****************************************
  logic [7:0] addrReg;
  logic wrPendReg;
  logic rdPendReg;
  logic [3:0] ctrlReg;
  logic [15:0] sizeReg;
  logic [15:0] countReg;
  logic [15:0] countNext;
  logic [3:0] slotReg;
  logic [1:0] quietReg;
  logic haltedReg;
  logic [31:0] hrdataReg;
  dbs_state_t stateReg;
  logic addrPhase;
  logic startPulse;
  logic engineReq;
  logic engineGrant;
  logic haltOk;
  logic lastBeat;
  logic reloadNow;
  logic windowEnd;
  logic engineSlotEnd;
  logic startNow;
  logic [31:0] statusWord;

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [31:0] st);
    if (a == CTRL_OFS) begin
      read_mux = {28'h0000000, ctrlReg};
    end else if (a == SIZE_OFS) begin
      read_mux = {16'h0000, sizeReg};
    end else if (a == STAT_OFS) begin
      read_mux = st;
    end else if (a == COUNT_OFS) begin
      read_mux = {16'h0000, countReg};
    end else begin
      read_mux = 32'h00000000;
    end
  endfunction : read_mux

  // slot index of the next cycle inside the ten-cycle window
  function automatic logic [3:0] next_slot(input logic [3:0] slot);
    if (slot == WINDOW_CYCLES - 4'd1) begin
      next_slot = 4'h0;
    end else begin
      next_slot = slot + 4'd1;
    end
  endfunction : next_slot

  // true on the granted cycle that moves the last unit of a transfer
  function automatic logic last_beat(input logic grant, input logic [15:0] count);
    last_beat = grant && count == 16'h0001;
  endfunction : last_beat

  // ****************************************
  // status word
  // ****************************************
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[STAT_ACTIVE_BIT] = stateReg != ST_IDLE;
    statusWord[STAT_BUSREQ_BIT] = engineReq;
    statusWord[STAT_CPUREQ_BIT] = sysIn.cpuReq;
    statusWord[STAT_HALTOK_BIT] = haltOk;
    statusWord[STAT_HALTED_BIT] = haltedReg;
    statusWord[STAT_WAIT_BIT] = sysIn.modWait;
  end

  // ****************************************
  // address phase capture
  // ****************************************
  assign addrPhase = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdataReg;

  always_ff @(posedge clk) begin
    if (rst) begin
      addrReg <= 8'h00;
      wrPendReg <= 1'b0;
      rdPendReg <= 1'b0;
    end else begin
      if (hready) begin
        addrReg <= haddr[7:0];
        wrPendReg <= addrPhase && hwrite;
        rdPendReg <= addrPhase && !hwrite;
      end
    end
  end

  // read data registered at the address phase edge so it stands in the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdataReg <= 32'h00000000;
    end else if (addrPhase && !hwrite) begin
      hrdataReg <= read_mux(haddr[7:0], statusWord);
    end
  end

  assign startPulse = wrPendReg && addrReg == CTRL_OFS && hwdata[CTRL_START_BIT]
                      && hwdata[CTRL_EN_BIT];

  // ****************************************
  // control and size registers
  // ****************************************
  // a software write wins over the hardware clear of enable
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlReg <= CTRL_RESET;
      sizeReg <= SIZE_RESET;
    end else begin
      if (wrPendReg && addrReg == CTRL_OFS) begin
        ctrlReg <= {1'b0, hwdata[2:0]};
      end else if (stateReg == ST_XFER && engineGrant && countReg == 16'h0001
                   && !ctrlReg[CTRL_REPEAT_BIT]) begin
        ctrlReg[CTRL_EN_BIT] <= 1'b0;
      end
      if (wrPendReg && addrReg == SIZE_OFS) begin
        sizeReg <= hwdata[15:0];
      end
    end
  end

  // ****************************************
  // transfer engine
  // ****************************************
  // a cycle is only used when the target module shows no wait state
  assign engineReq = stateReg != ST_IDLE;
  assign engineGrant = stateReg == ST_XFER && !sysIn.modWait;

  assign lastBeat = last_beat(engineGrant, countReg);
  assign reloadNow = lastBeat && ctrlReg[CTRL_REPEAT_BIT] && ctrlReg[CTRL_EN_BIT];
  assign windowEnd = slotReg == WINDOW_CYCLES - 4'd1;
  assign engineSlotEnd = ctrlReg[CTRL_BURST_BIT] && slotReg == ENGINE_SLOTS - 4'd1;
  assign startNow = startPulse && sizeReg != 16'h0000;

  always_comb begin
    countNext = countReg;
    if (reloadNow) begin
      countNext = sizeReg;
    end else if (engineGrant) begin
      countNext = countReg - 16'h0001;
    end
  end

  // ****************************************
  // size counter
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      countReg <= 16'h0000;
    end else if (stateReg == ST_IDLE) begin
      if (startNow) begin
        countReg <= sizeReg;
      end
    end else if (stateReg == ST_XFER) begin
      countReg <= countNext;
    end
  end

  // ****************************************
  // window slot counter
  // ****************************************
  // wait-state cycles still use up their slot, so the core keeps its two cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      slotReg <= 4'h0;
    end else if (stateReg == ST_IDLE) begin
      slotReg <= 4'h0;
    end else begin
      slotReg <= next_slot(slotReg);
    end
  end

  // ****************************************
  // channel state
  // ****************************************
  // a reload on the last engine slot still hands the next two cycles to the core
  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg <= ST_IDLE;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (startNow) begin
            stateReg <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (lastBeat && !reloadNow) begin
            stateReg <= ST_IDLE;
          end else if (!lastBeat && !ctrlReg[CTRL_EN_BIT]) begin
            stateReg <= ST_IDLE;
          end else if (engineSlotEnd) begin
            stateReg <= ST_CPU;
          end
        end
        ST_CPU: begin
          if (!ctrlReg[CTRL_EN_BIT]) begin
            stateReg <= ST_IDLE;
          end else if (windowEnd) begin
            stateReg <= ST_XFER;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // debug halt gate
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      quietReg <= 2'd0;
    end else if (engineReq) begin
      quietReg <= 2'd0;
    end else if (quietReg != QUIET_CYCLES) begin
      quietReg <= quietReg + 2'd1;
    end
  end

  assign haltOk = quietReg == QUIET_CYCLES && !engineReq && !sysIn.cpuReq;

  always_ff @(posedge clk) begin
    if (rst) begin
      haltedReg <= 1'b0;
    end else if (!sysIn.haltReq) begin
      haltedReg <= 1'b0;
    end else if (haltOk) begin
      haltedReg <= 1'b1;
    end
  end

  // ****************************************
  // system side outputs
  // ****************************************
  always_comb begin
    sysOut.engineReq = engineReq;
    sysOut.engineGrant = engineGrant;
    sysOut.cpuGrant = !engineReq || stateReg == ST_CPU;
    sysOut.haltGrant = haltedReg;
  end

endmodule : dbs_engine
`default_nettype wire

//--- bench/dbs_engine_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dbs_engine_checker
  import dbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire dbs_sys_in_t sysIn,
  input wire dbs_sys_out_t sysOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_EXCL: assert property (sysOut.engineGrant |-> !sysOut.cpuGrant)
    else $error("engine and core both granted");
  AST_WAIT: assert property (sysIn.modWait |-> !sysOut.engineGrant)
    else $error("engine access during wait state");
  AST_IDLE: assert property (!sysOut.engineReq |-> sysOut.cpuGrant && !sysOut.engineGrant)
    else $error("idle engine holds the bus");
  AST_CPU: assert property ($rose(sysOut.haltGrant) |-> !$past(sysIn.cpuReq))
    else $error("halt while core requests bus");
  AST_QUIET: assert property ($rose(sysOut.haltGrant) |-> !$past(sysOut.engineReq, 1)
    && !$past(sysOut.engineReq, 2) && !$past(sysOut.engineReq, 3)) else $error("halt too soon");
  AST_DROP: assert property (!sysIn.haltReq |=> !sysOut.haltGrant)
    else $error("halt kept without request");
  AST_SLOT: assert property ($rose(sysOut.engineReq && sysOut.cpuGrant) |-> ##1
    sysOut.cpuGrant ##1 (!sysOut.cpuGrant || !sysOut.engineReq)) else $error("core slot not 2");
  AST_EIGHT: assert property ($rose(sysOut.engineReq && sysOut.cpuGrant) |->
    !$past(sysOut.cpuGrant, 1) && !$past(sysOut.cpuGrant, 8) && $past(sysOut.cpuGrant, 9))
    else $error("engine slot not 8");
endmodule : dbs_engine_checker
bind dbs_engine dbs_engine_checker i_chk (.clk(clk), .rst(rst), .sysIn(sysIn), .sysOut(sysOut));
`default_nettype wire

//--- bench/dbs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbs_core_model
  import dbs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cpuWant,
  input wire logic haltWant,
  input wire logic modBusy,
  output dbs_sys_in_t sysIn
);
  always_ff @(posedge clk) begin
    if (rst) begin
      sysIn <= '0;
    end else begin
      sysIn.cpuReq <= cpuWant;
      sysIn.haltReq <= haltWant;
      sysIn.modWait <= modBusy & ~sysIn.modWait;
    end
  end
endmodule : dbs_core_model
`default_nettype wire

//--- bench/tb_dma_bus_share_debug_halt.sv
`timescale 1ns/1ns
`default_nettype none
module tb_dma_bus_share_debug_halt;
  import dbs_pkg::*;
  typedef struct {logic [15:0] size; logic [3:0] ctrl; logic busy; int grants; int slots;} dbs_row_t;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic cpuWant = 1'b0, haltWant = 1'b0, modBusy = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  dbs_sys_in_t sysIn;
  dbs_sys_out_t sysOut;
  int nErrors = 0, nChecks = 0, k, g, s;
  dbs_row_t rows[5] = '{'{16'h1, 4'h9, 1'b0, 1, 0}, '{16'h3, 4'h9, 1'b1, 3, 0},
    '{16'h8, 4'hd, 1'b0, 8, 0}, '{16'h9, 4'hd, 1'b0, 9, 2}, '{16'h14, 4'hd, 1'b0, 20, 4}};
  always #4 clk = ~clk;
  dbs_engine i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sysIn(sysIn), .sysOut(sysOut));
  dbs_core_model i_core (.clk(clk), .rst(rst), .cpuWant(cpuWant), .haltWant(haltWant),
    .modBusy(modBusy), .sysIn(sysIn));
  task summarize;
    $display("errors=%0d checks=%0d", nErrors, nChecks);
    if (nErrors == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task hwait;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 50) begin
      nErrors++;
      summarize();
    end
  endtask : hwait
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    rd = hrdata;
  endtask : ahb
  initial begin
    repeat (2) @(posedge clk);
    #1 chk({28'h0, sysOut}, 32'h2);
    chk({31'h0, hresp}, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      modBusy <= rows[i].busy;
      ahb(1'b1, SIZE_OFS, {16'h0, rows[i].size});
      ahb(1'b1, CTRL_OFS, {28'h0, rows[i].ctrl});
      #1 g = 0;
      s = 0;
      for (k = 0; k < 300 && sysOut.engineReq === 1'b1; k++) begin
        g += sysOut.engineGrant;
        s += sysOut.engineReq & sysOut.cpuGrant;
        @(posedge clk);
        #1;
      end
      chk(g, rows[i].grants);
      chk(s, rows[i].slots);
      ahb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, {28'h0, rows[i].ctrl & 4'h6});
      ahb(1'b0, COUNT_OFS, 32'h0);
      chk(rd, 32'h0);
    end
    modBusy <= 1'b0;
    cpuWant <= 1'b1;
    haltWant <= 1'b1;
    ahb(1'b1, SIZE_OFS, 32'h2);
    ahb(1'b1, CTRL_OFS, 32'hf);
    repeat (40) @(posedge clk);
    #1 chk({sysOut.engineReq, sysOut.haltGrant}, 32'h2);
    ahb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h7);
    ahb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h7);
    ahb(1'b1, CTRL_OFS, 32'h0);
    repeat (10) @(posedge clk);
    #1 chk({sysOut.engineReq, sysOut.haltGrant}, 32'h0);
    @(posedge clk);
    cpuWant <= 1'b0;
    for (k = 0; k < 10 && sysOut.haltGrant !== 1'b1; k++) @(posedge clk);
    chk(sysOut.haltGrant, 32'h1);
    ahb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h18);
    haltWant <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(sysOut.haltGrant, 32'h0);
    summarize();
  end
endmodule : tb_dma_bus_share_debug_halt
`default_nettype wire
